/* pkg/otp_pkg.sv */
package otp_pkg;
  localparam int CLK_HZ       = 40_000_000;
  localparam int TICK_MS      = 10;
  localparam int START_WIN_MS = 60;
  localparam int CNT_W        = 22;
  // Delay settings count 10 ms ticks
  localparam logic [15:0] LOW_DLY_MIN  = 16'h0005;
  localparam logic [15:0] HIGH_DLY_MIN = 16'h0004;
  localparam logic [15:0] DLY_MAX      = 16'h7530;
  // Currents and thresholds count 0.01 x rated current
  localparam logic [15:0] INV_THR_MAX  = 16'h00fa;
  localparam logic [15:0] HIGH_THR_MIN = 16'h0032;
  localparam logic [15:0] HIGH_THR_MAX = 16'h0fa0;
  // Starting situation ratios: current x DEN against threshold x NUM
  localparam logic [23:0] ARM_NUM   = 24'h00000c;
  localparam logic [23:0] ARM_DEN   = 24'h000064;
  localparam logic [23:0] ENTER_NUM = 24'h000003;
  localparam logic [23:0] ENTER_DEN = 24'h000002;
  localparam logic [23:0] EXIT_NUM  = 24'h000005;
  localparam logic [23:0] EXIT_DEN  = 24'h000004;
  // Switch bit positions
  localparam int FS1_MODE_LSB  = 1;
  localparam int FS1_MODE_MSB  = 3;
  localparam int FS1_DOUBLE    = 5;
  localparam int FS2_AUX_TRIP  = 1;
  localparam int FS2_HIGH_OFF  = 5;
  localparam int BCS_BLK_LOW   = 1;
  localparam int BCS_BLK_HIGH  = 2;
  localparam int BCS_LATCH     = 6;
  // Characteristic codes
  localparam logic [2:0] MODE_DEF      = 3'h0;
  localparam logic [2:0] MODE_NORMAL   = 3'h1;
  localparam logic [2:0] MODE_VERY     = 3'h2;
  localparam logic [2:0] MODE_EXTREME  = 3'h3;
  localparam logic [2:0] MODE_LONG     = 3'h4;
  localparam logic [2:0] MODE_SPEC_A   = 3'h5;
  localparam logic [2:0] MODE_SPEC_B   = 3'h6;
  localparam logic [2:0] MODE_DEF_ALT  = 3'h7;
  typedef enum logic [1:0] {SIT_IDLE, SIT_ARMED, SIT_RISING, SIT_ACTIVE} otp_sit_t;
endpackage

/* rtl/otp_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module otp_timer
  import otp_pkg::*;
(
  input  wire logic        clk_in,      // System clock
  input  wire logic        reset_in,    // Sync reset
  input  wire logic        run_in,      // Stage started
  input  wire logic        tick_in,     // 10 ms tick
  input  wire logic [7:0]  step_in,     // Ticks added per tick
  input  wire logic [15:0] limit_in,    // Operating delay
  output logic             expired_out  // Delay passed
);
  logic [15:0] acc_r;
  logic [15:0] acc_nxt;

  assign acc_nxt = !run_in ? 16'h0000 :
                   (tick_in && !expired_out) ? acc_r + {8'h00, step_in} : acc_r;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      acc_r       <= 16'h0000;
      expired_out <= 1'b0;
    end
    else
    begin
      acc_r       <= acc_nxt;
      expired_out <= run_in && (acc_r >= limit_in);
    end
  end

  a_timer_clear: assert property (@(posedge clk_in) disable iff (reset_in)
    !run_in |=> (acc_r == 16'h0000) && !expired_out)
    else $error("timer not cleared on drop-out");
endmodule // otp_timer
`default_nettype wire

/* rtl/otp_start_det.sv */
`timescale 1ns/1ps
`default_nettype none
module otp_start_det
  import otp_pkg::*;
#(
  parameter int WIN_CYCLES = START_WIN_MS * (CLK_HZ / 1000)
)
(
  input  wire logic        clk_in,     // System clock
  input  wire logic        reset_in,   // Sync reset
  input  wire logic [15:0] i_max_in,   // Highest phase current
  input  wire logic [15:0] thr_in,     // Low-set threshold
  output logic             active_out  // Starting situation
);
  otp_sit_t         st_r;
  logic [CNT_W-1:0] win_r;
  logic [23:0]      i_w;
  logic [23:0]      t_w;
  logic             below_arm;
  logic             above_enter;
  logic             below_exit;
  logic             win_end;

  assign i_w         = {8'h00, i_max_in};
  assign t_w         = {8'h00, thr_in};
  assign below_arm   = (i_w * ARM_DEN) < (t_w * ARM_NUM);
  assign above_enter = (i_w * ENTER_DEN) > (t_w * ENTER_NUM);
  assign below_exit  = (i_w * EXIT_DEN) < (t_w * EXIT_NUM);
  assign win_end     = (win_r >= CNT_W'(WIN_CYCLES - 1));

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      st_r       <= SIT_IDLE;
      win_r      <= '0;
      active_out <= 1'b0;
    end
    else
    begin
      win_r <= (st_r == SIT_RISING) ? win_r + 1'b1 : '0;
      case (st_r)
        SIT_IDLE:   if (below_arm) st_r <= SIT_ARMED;
        SIT_ARMED:  if (above_enter) st_r <= SIT_ACTIVE;
                    else if (!below_arm) st_r <= SIT_RISING;
        SIT_RISING: if (above_enter) st_r <= SIT_ACTIVE;
                    else if (below_arm) st_r <= SIT_ARMED;
                    else if (win_end) st_r <= SIT_IDLE;
        SIT_ACTIVE: if (below_exit) st_r <= SIT_IDLE;
        default:    st_r <= SIT_IDLE;
      endcase
      active_out <= (st_r == SIT_ACTIVE) ? !below_exit : above_enter &&
                    (st_r == SIT_ARMED || st_r == SIT_RISING);
    end
  end

  a_sit_enter: assert property (@(posedge clk_in) disable iff (reset_in)
    (st_r == SIT_RISING) && above_enter |=> active_out)
    else $error("fast rise not seen as starting situation");
  a_sit_end: assert property (@(posedge clk_in) disable iff (reset_in)
    active_out && below_exit |=> !active_out)
    else $error("starting situation did not end");
endmodule // otp_start_det
`default_nettype wire

/* rtl/otp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module otp_top
  import otp_pkg::*;
#(
  parameter int TICK_CYCLES      = TICK_MS * (CLK_HZ / 1000),
  parameter int START_WIN_CYCLES = START_WIN_MS * (CLK_HZ / 1000)
)
(
  input  wire logic        clk_in,                    // 40 MHz clock
  input  wire logic        reset_in,                  // Sync reset
  input  wire logic [15:0] phase_a_in,                // Phase A, 0.01 In
  input  wire logic [15:0] phase_b_in,                // Phase B, 0.01 In
  input  wire logic [15:0] phase_c_in,                // Phase C, 0.01 In
  input  wire logic [15:0] low_stage_threshold_in,    // Low-set, 0.01 In
  input  wire logic [15:0] high_stage_threshold_in,   // High-set, 0.01 In
  input  wire logic [14:0] low_stage_delay_in,        // 10 ms units
  input  wire logic [14:0] high_stage_delay_in,       // 10 ms units
  input  wire logic [8:1]  function_switches_1_in,    // Mode, doubling
  input  wire logic [8:1]  function_switches_2_in,    // Aux trip, high off
  input  wire logic [8:1]  block_config_switches_in,  // Blocking, latch
  input  wire logic        block_in,                  // Blocking pin
  input  wire logic        reset_button_in,           // Front reset key
  input  wire logic        program_button_in,         // Front program key
  output logic             low_stage_start_out,       // Low-set started
  output logic             high_stage_start_out,      // High start or aux
  output logic             breaker_trip_out,          // Breaker trip
  output logic             trip_indicator_out,        // Red indicator
  output logic             start_display_out,         // Start on display
  output logic             high_stage_off_out,        // Dashed readout
  output logic             starting_situation_out     // Energization seen
);
  // Pin synchronisers: block, reset key, program key
  logic [2:0]       pin_s1_r;
  logic [2:0]       pin_s2_r;
  logic             block_s;
  logic             rst_key_s;
  logic             prog_key_s;

  logic [CNT_W-1:0] tick_cnt_r;
  logic             tick_r;

  logic [15:0]      i_ab;
  logic [15:0]      i_max;
  logic [2:0]       mode;
  logic             inv_mode;
  logic [15:0]      low_thr_eff;
  logic [15:0]      high_thr_set;
  logic [16:0]      high_thr_eff;
  logic             sit_active;
  logic             high_off;
  logic             low_blk;
  logic             high_blk;
  logic             low_pick;
  logic             high_pick;
  logic             low_start_r;
  logic             high_start_r;
  logic [15:0]      low_limit;
  logic [15:0]      high_limit;
  logic [7:0]       low_step;
  logic             low_exp;
  logic             high_exp;
  logic             trip_cond;
  logic             latch_en;
  logic             both_keys;
  logic             trip_nxt;
  logic             ind_nxt;
  logic             aux_en;

  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Piecewise time steps per tick; a heavier multiple of threshold
  // advances the timer faster, so the delay setting acts as multiplier
  function automatic logic [7:0] curve_step(input logic [2:0]  md,
                                            input logic [15:0] i,
                                            input logic [15:0] t);
    logic       m2;
    logic       m4;
    logic       m8;
    logic [7:0] base;
    m2   = {1'b0, i} >= {t, 1'b0};
    m4   = {2'b00, i} >= {t, 2'b00};
    m8   = {3'b000, i} >= {t, 3'b000};
    base = m8 ? 8'h08 : (m4 ? 8'h04 : (m2 ? 8'h02 : 8'h01));
    case (md)
      MODE_NORMAL:  curve_step = base;
      MODE_VERY:    curve_step = base << 1;
      MODE_EXTREME: curve_step = base << 2;
      MODE_LONG:    curve_step = m2 ? base >> 1 : 8'h01;
      MODE_SPEC_A:  curve_step = m2 ? base << 1 : 8'h01;
      MODE_SPEC_B:  curve_step = m8 ? 8'h20 : base;
      default:      curve_step = 8'h01;
    endcase
  endfunction

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
    end
    else
    begin
      pin_s1_r <= {block_in, reset_button_in, program_button_in};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign block_s    = pin_s2_r[2];
  assign rst_key_s  = pin_s2_r[1];
  assign prog_key_s = pin_s2_r[0];

  // One 10 ms tick keeps the delay counters narrow
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end
    else
    begin
      tick_r     <= (tick_cnt_r == CNT_W'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == CNT_W'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  assign i_ab  = (phase_a_in > phase_b_in) ? phase_a_in : phase_b_in;
  assign i_max = (i_ab > phase_c_in) ? i_ab : phase_c_in;

  assign mode     = function_switches_1_in[FS1_MODE_MSB:FS1_MODE_LSB];
  assign inv_mode = (mode != MODE_DEF) && (mode != MODE_DEF_ALT);

  assign low_thr_eff = (inv_mode && (low_stage_threshold_in > INV_THR_MAX)) ?
                       INV_THR_MAX : low_stage_threshold_in;

  otp_start_det #(
    .WIN_CYCLES (START_WIN_CYCLES)
  ) u_start_det (
    .clk_in     (clk_in),
    .reset_in   (reset_in),
    .i_max_in   (i_max),
    .thr_in     (low_thr_eff),
    .active_out (sit_active)
  );

  assign high_thr_set = clamp16(high_stage_threshold_in,
                                HIGH_THR_MIN, HIGH_THR_MAX);
  assign high_thr_eff = (function_switches_1_in[FS1_DOUBLE] && sit_active) ?
                        {high_thr_set, 1'b0} : {1'b0, high_thr_set};

  assign high_off = function_switches_2_in[FS2_HIGH_OFF];
  assign low_blk  = block_s && block_config_switches_in[BCS_BLK_LOW];
  assign high_blk = block_s && block_config_switches_in[BCS_BLK_HIGH];

  assign high_pick = !high_off && !high_blk &&
                     ({1'b0, i_max} > high_thr_eff);
  // In the inverse modes a started high stage takes over at heavy fault currents
  assign low_pick  = !low_blk && (i_max > low_thr_eff) &&
                     !(inv_mode && high_start_r);

  assign low_limit  = clamp16({1'b0, low_stage_delay_in},
                              LOW_DLY_MIN, DLY_MAX);
  assign high_limit = clamp16({1'b0, high_stage_delay_in},
                              HIGH_DLY_MIN, DLY_MAX);
  assign low_step   = inv_mode ? curve_step(mode, i_max, low_thr_eff) : 8'h01;

  otp_timer u_low_timer (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .run_in      (low_start_r),
    .tick_in     (tick_r),
    .step_in     (low_step),
    .limit_in    (low_limit),
    .expired_out (low_exp)
  );

  otp_timer u_high_timer (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .run_in      (high_start_r),
    .tick_in     (tick_r),
    .step_in     (8'h01),
    .limit_in    (high_limit),
    .expired_out (high_exp)
  );

  assign trip_cond = low_exp || high_exp;
  assign latch_en  = block_config_switches_in[BCS_LATCH];
  assign both_keys = rst_key_s && prog_key_s;
  // A new trip outranks a release requested in the same cycle
  assign trip_nxt  = trip_cond ||
                     (latch_en && breaker_trip_out && !both_keys);
  assign ind_nxt   = trip_cond || (trip_indicator_out && !rst_key_s);
  assign aux_en    = function_switches_2_in[FS2_AUX_TRIP];

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      low_start_r            <= 1'b0;
      high_start_r           <= 1'b0;
      low_stage_start_out    <= 1'b0;
      high_stage_start_out   <= 1'b0;
      breaker_trip_out       <= 1'b0;
      trip_indicator_out     <= 1'b0;
      start_display_out      <= 1'b0;
      high_stage_off_out     <= 1'b0;
      starting_situation_out <= 1'b0;
    end
    else
    begin
      low_start_r            <= low_pick;
      high_start_r           <= high_pick;
      low_stage_start_out    <= low_pick;
      high_stage_start_out   <= high_pick || (aux_en && trip_nxt);
      breaker_trip_out       <= trip_nxt;
      trip_indicator_out     <= ind_nxt;
      start_display_out      <= low_pick || high_pick;
      high_stage_off_out     <= high_off;
      starting_situation_out <= sit_active;
    end
  end

  a_low_start_follows: assert property (@(posedge clk_in) disable iff (reset_in)
    ($past(i_max) > $past(low_thr_eff)) && !$past(low_blk) && !$past(inv_mode)
    |-> low_stage_start_out)
    else $error("low stage did not start above threshold");

  a_start_display: assert property (@(posedge clk_in) disable iff (reset_in)
    low_stage_start_out |-> start_display_out)
    else $error("start not flagged to display");

  a_trip_cause: assert property (@(posedge clk_in) disable iff (reset_in)
    $rose(breaker_trip_out) |-> $past(low_exp) || $past(high_exp))
    else $error("trip raised without expired delay");

  a_indicator_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    trip_indicator_out && !rst_key_s |=> trip_indicator_out)
    else $error("indicator cleared without reset key");

  a_aux_route: assert property (@(posedge clk_in) disable iff (reset_in)
    aux_en && trip_cond |=> high_stage_start_out && breaker_trip_out)
    else $error("auxiliary trip not routed");

  a_block_low: assert property (@(posedge clk_in) disable iff (reset_in)
    block_s && block_config_switches_in[BCS_BLK_LOW] |=> !low_stage_start_out)
    else $error("blocked low stage started");

  a_block_high: assert property (@(posedge clk_in) disable iff (reset_in)
    block_s && block_config_switches_in[BCS_BLK_HIGH] |=> !high_start_r)
    else $error("blocked high stage started");

  a_latch_hold: assert property (@(posedge clk_in) disable iff (reset_in)
    latch_en && breaker_trip_out && !both_keys |=> breaker_trip_out)
    else $error("latched trip dropped");

  a_unlatched_drop: assert property (@(posedge clk_in) disable iff (reset_in)
    !latch_en && !trip_cond |=> !breaker_trip_out)
    else $error("unlatched trip held");

  a_double_thr: assert property (@(posedge clk_in) disable iff (reset_in)
    function_switches_1_in[FS1_DOUBLE] && sit_active &&
    ({1'b0, i_max} <= {high_thr_set, 1'b0}) |=> !high_start_r)
    else $error("high stage ignored doubled threshold");

  a_high_off: assert property (@(posedge clk_in) disable iff (reset_in)
    high_off |=> !high_start_r ##0 high_stage_off_out)
    else $error("disabled high stage started");

  a_inv_clamp: assert property (@(posedge clk_in) disable iff (reset_in)
    inv_mode && (i_max > INV_THR_MAX) && !low_blk && !high_start_r
    |=> low_stage_start_out)
    else $error("inverse threshold not capped");

  a_inv_block: assert property (@(posedge clk_in) disable iff (reset_in)
    inv_mode && high_start_r |=> !low_start_r)
    else $error("inverse low stage ran beside high start");

  a_drop_reset: assert property (@(posedge clk_in) disable iff (reset_in)
    !low_start_r |=> !low_exp)
    else $error("low timer survived drop-out");
endmodule // otp_top
`default_nettype wire

/* test/otp_phase_src.sv */
`timescale 1ns/1ps
`default_nettype none
module otp_phase_src
(
  input  wire logic        clk_in,      // System clock
  input  wire logic [15:0] level_in,    // Commanded fault current
  input  wire logic [1:0]  sel_in,      // Faulted phase
  input  wire logic        trip_in,     // Breaker coil drive
  output logic      [15:0] phase_a_out, // Phase A magnitude
  output logic      [15:0] phase_b_out, // Phase B magnitude
  output logic      [15:0] phase_c_out, // Phase C magnitude
  output logic      [7:0]  trips_out    // Breaker operations seen
);
  logic       noise_r = 1'b0;
  logic       trip_r  = 1'b0;
  logic [7:0] trips_r = 8'h00;

  assign trips_out = trips_r;
  // Healthy phases carry a flickering light load, never a clean constant
  always @(negedge clk_in)
  begin
    noise_r     <= ~noise_r;
    phase_a_out <= (sel_in == 2'h0) ? level_in : {15'h0000, noise_r};
    phase_b_out <= (sel_in == 2'h1) ? level_in : {15'h0000, ~noise_r};
    phase_c_out <= (sel_in == 2'h2) ? level_in : {15'h0000, noise_r};
  end
  // The count moves one edge after the trip rises
  always @(posedge clk_in)
  begin
    trip_r <= trip_in;
    if (trip_in && !trip_r)
      trips_r <= trips_r + 8'h01;
  end
endmodule // otp_phase_src
`default_nettype wire

/* test/test_two_stage_overcurrent_protection.sv */
`timescale 1ns/1ps
`default_nettype none
module test_two_stage_overcurrent_protection;
  import otp_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [15:0] level, lo_thr, hi_thr, ph_a, ph_b, ph_c;
  logic [14:0] lo_dly, hi_dly;
  logic [8:1]  fs1, fs2, bcs;
  logic [1:0]  sel;
  logic [7:0]  trips;
  logic        blk, rst_key, prg_key;
  logic        lo_st, hi_st, trip, ind, disp, hi_off, sit;
  int          fail_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n;

  otp_top #(.TICK_CYCLES(4), .START_WIN_CYCLES(40)) i_dut (
    .clk_in(clk_in), .reset_in(reset_in),
    .phase_a_in(ph_a), .phase_b_in(ph_b), .phase_c_in(ph_c),
    .low_stage_threshold_in(lo_thr), .high_stage_threshold_in(hi_thr),
    .low_stage_delay_in(lo_dly), .high_stage_delay_in(hi_dly),
    .function_switches_1_in(fs1), .function_switches_2_in(fs2),
    .block_config_switches_in(bcs), .block_in(blk),
    .reset_button_in(rst_key), .program_button_in(prg_key),
    .low_stage_start_out(lo_st), .high_stage_start_out(hi_st),
    .breaker_trip_out(trip), .trip_indicator_out(ind),
    .start_display_out(disp), .high_stage_off_out(hi_off),
    .starting_situation_out(sit));

  otp_phase_src i_src (
    .clk_in(clk_in), .level_in(level), .sel_in(sel), .trip_in(trip),
    .phase_a_out(ph_a), .phase_b_out(ph_b), .phase_c_out(ph_c), .trips_out(trips));

  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end

  // Ceiling well above the summed scenario lengths
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(negedge clk_in);
  endtask

  // Current reaches the pins one falling edge after it is commanded
  task automatic drive(input logic [15:0] lv, input int k);
    level <= lv;
    cyc_n(k);
  endtask

  task automatic wait_trip(input int lim, output int cnt);
    cnt = 0;
    while (trip !== 1'b1 && cnt < lim)
    begin
      @(negedge clk_in);
      cnt++;
    end
  endtask

  task automatic defaults();
    @(negedge clk_in);
    reset_in <= 1'b1;
    level    <= 16'h0000;
    sel      <= 2'h0;
    lo_thr   <= 16'h0064;
    hi_thr   <= 16'h0fa0;
    lo_dly   <= 15'h7530;
    hi_dly   <= 15'h7530;
    fs1      <= 8'h00;
    fs2      <= 8'h00;
    bcs      <= 8'h00;
    blk      <= 1'b0;
    rst_key  <= 1'b0;
    prg_key  <= 1'b0;
    cyc_n(3);
    reset_in <= 1'b0;
    cyc_n(4);
  endtask

  task automatic t_low_start();
    defaults();
    lo_dly <= 15'h0005;
    sel    <= 2'h1;
    drive(16'h0064, 4);
    chk(lo_st, 1'b0);
    drive(16'h0065, 4);
    chk(lo_st, 1'b1);
    chk(disp, 1'b1);
    chk(hi_st, 1'b0);
    drive(16'h0064, 4);
    chk(lo_st, 1'b0);
    chk(disp, 1'b0);
    cyc_n(40);
    chk(trip, 1'b0);
  endtask

  task automatic t_def_trip();
    defaults();
    lo_dly <= 15'h0005;
    sel    <= 2'h2;
    drive(16'h00c8, 3);
    wait_trip(40, n);
    chk(n >= 14 && n <= 30, 1'b1);
    chk(ind, 1'b1);
    drive(16'h0000, 8);
    chk(trips, 8'h01);
    chk(trip, 1'b0);
    chk(ind, 1'b1);
    rst_key <= 1'b1;
    cyc_n(5);
    rst_key <= 1'b0;
    cyc_n(2);
    chk(ind, 1'b0);
  endtask

  task automatic t_high();
    defaults();
    hi_thr <= 16'h012c;
    hi_dly <= 15'h0004;
    drive(16'h012c, 4);
    chk(hi_st, 1'b0);
    chk(lo_st, 1'b1);
    drive(16'h012d, 4);
    chk(hi_st, 1'b1);
    wait_trip(40, n);
    chk(n >= 10 && n <= 28, 1'b1);
    drive(16'h0000, 8);
    fs2[5] <= 1'b1;
    cyc_n(3);
    chk(hi_off, 1'b1);
    drive(16'h0190, 4);
    chk(hi_st, 1'b0);
    fs2[5] <= 1'b0;
    hi_thr <= 16'h0010;
    drive(16'h0028, 4);
    chk(hi_off, 1'b0);
    chk(hi_st, 1'b0);
    drive(16'h0033, 4);
    chk(hi_st, 1'b1);
  endtask

  task automatic t_block();
    defaults();
    bcs[1] <= 1'b1;
    blk    <= 1'b1;
    hi_thr <= 16'h006e;
    cyc_n(6);
    drive(16'h0078, 4);
    chk(lo_st, 1'b0);
    chk(hi_st, 1'b1);
    bcs    <= 8'h02;
    cyc_n(4);
    chk(lo_st, 1'b1);
    chk(hi_st, 1'b0);
    blk <= 1'b0;
    cyc_n(6);
    chk(hi_st, 1'b1);
  endtask

  task automatic t_latch();
    defaults();
    bcs[6] <= 1'b1;
    lo_dly <= 15'h0005;
    drive(16'h00c8, 3);
    wait_trip(40, n);
    chk(trip, 1'b1);
    drive(16'h0000, 10);
    chk(trip, 1'b1);
    rst_key <= 1'b1;
    cyc_n(5);
    chk(trip, 1'b1);
    rst_key <= 1'b0;
    prg_key <= 1'b1;
    cyc_n(5);
    chk(trip, 1'b1);
    rst_key <= 1'b1;
    cyc_n(6);
    chk(trip, 1'b0);
    rst_key <= 1'b0;
    prg_key <= 1'b0;
  endtask

  task automatic t_aux();
    defaults();
    fs2[1] <= 1'b1;
    lo_dly <= 15'h0005;
    drive(16'h00c8, 3);
    chk(hi_st, 1'b0);
    wait_trip(40, n);
    cyc_n(1);
    chk(hi_st, 1'b1);
  endtask

  // Threshold 4.0 is capped at 2.5 only by the inverse curves
  task automatic t_modes();
    defaults();
    lo_thr <= 16'h0190;
    sel    <= 2'h1;
    drive(16'h012c, 2);
    for (int m = 0; m < 8; m++)
    begin
      fs1 <= {5'h00, m[2:0]};
      cyc_n(4);
      chk(lo_st, (m != 0 && m != 7));
    end
    lo_thr <= 16'h0064;
    hi_thr <= 16'h00c8;
    fs1    <= 8'h01;
    cyc_n(4);
    chk(hi_st, 1'b1);
    chk(lo_st, 1'b0);
    fs1 <= 8'h00;
    cyc_n(4);
    chk(lo_st, 1'b1);
  endtask

  task automatic t_start_sit();
    defaults();
    fs1[5] <= 1'b1;
    hi_thr <= 16'h012c;
    cyc_n(3);
    drive(16'h012d, 5);
    chk(sit, 1'b1);
    chk(hi_st, 1'b0);
    drive(16'h0082, 5);
    chk(sit, 1'b1);
    drive(16'h007c, 5);
    chk(sit, 1'b0);
    drive(16'h012d, 5);
    chk(sit, 1'b0);
    chk(hi_st, 1'b1);
    defaults();
    drive(16'h000a, 3);
    drive(16'h0020, 60);
    drive(16'h012d, 5);
    chk(sit, 1'b0);
    // Rise through the middle band inside the window, doubling off
    hi_thr <= 16'h012c;
    drive(16'h000a, 3);
    drive(16'h0020, 10);
    drive(16'h012d, 5);
    chk(sit, 1'b1);
    chk(hi_st, 1'b1);
  endtask

  initial
  begin
    level   = 16'h0000;
    sel     = 2'h0;
    lo_thr  = 16'h0064;
    hi_thr  = 16'h0fa0;
    lo_dly  = 15'h7530;
    hi_dly  = 15'h7530;
    fs1     = 8'h00;
    fs2     = 8'h00;
    bcs     = 8'h00;
    blk     = 1'b0;
    rst_key = 1'b0;
    prg_key = 1'b0;
    cyc_n(12);
    chk(trip, 1'b0);
    t_low_start();
    t_def_trip();
    t_high();
    t_block();
    t_latch();
    t_aux();
    t_modes();
    t_start_sit();
    report_and_stop();
  end
endmodule // test_two_stage_overcurrent_protection
`default_nettype wire
